/* include/rsmux_pkg.sv */
// Purpose: Shared constants and types for the registered one-of-sixteen selector.
// Assumes: Select code is four bits wide, sixteen data inputs.
// Notes:   Variant enumeration chooses clocked or hold-enable select capture.
package rsmux_pkg;

  localparam int unsigned SEL_W     = 4;
  localparam int unsigned DATA_N    = 16;
  localparam logic [3:0]  SEL_RESET = 4'h0;
  // Idle levels of master, true and inverted enables, in pin order: both outputs float.
  localparam logic [2:0]  CTRL_IDLE = 3'h6;

  typedef enum logic [0:0] {
    RSMUX_CLOCKED = 1'b0,
    RSMUX_HOLD    = 1'b1
  } rsmux_variant_t;

endpackage : rsmux_pkg

/* include/rsmux_sel_if.sv */
// Purpose: Carries the applied select code from the capture stage to the decoder.
// Assumes: One clock domain.
// Notes:   The capture stage drives, the top module reads.
`timescale 1ns/10ps
interface rsmux_sel_if;
  import rsmux_pkg::*;
  logic [SEL_W-1:0] code;
  logic             known;
  modport src (output code, output known);
  modport dst (input code, input known);
endinterface : rsmux_sel_if

/* logic/rsmux_sel_reg.sv */
// Purpose: Select code capture stage, clocked or hold-enable controlled.
// Assumes: Pin inputs already synchronised by the caller.
// Notes:   Hold edge is detected on the synchronised enable in the core clock.
`timescale 1ns/10ps
module rsmux_sel_reg
  import rsmux_pkg::*;
#(
  parameter rsmux_variant_t VARIANT = RSMUX_CLOCKED
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [SEL_W-1:0] sel_in,
  input  wire logic             hold,
  rsmux_sel_if.src              sel
);

  typedef struct packed {
    logic [SEL_W-1:0] code;
    logic             known;
    logic             hold_d;
  } rsmux_cap_t;

  rsmux_cap_t st;
  rsmux_cap_t next_st;

  always_comb begin
    next_st        = st;
    next_st.hold_d = hold;
    if (VARIANT == RSMUX_CLOCKED) begin
      // Every core edge stands for a rising capture edge.
      next_st.code  = sel_in; // [RULE3] [RULE8]
      next_st.known = 1'b1; // [RULE10]
    end else if (!hold || !st.hold_d) begin
      // Transparent while low; the value present at the rising edge is kept.
      next_st.code  = sel_in; // [RULE4] [RULE9]
      next_st.known = 1'b1; // [RULE10]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{code: SEL_RESET, known: 1'b0, hold_d: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign sel.code  = st.code;
  assign sel.known = st.known;

  property p_hold_keeps;
    @(posedge clk) disable iff (rst)
    (VARIANT == RSMUX_HOLD && hold && $past(hold)) |=> $stable(st.code);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) // [RULE9]
    else $error("select changed while hold asserted");

endmodule : rsmux_sel_reg

/* logic/rsmux_top.sv */
// Purpose: One-of-sixteen data selector with true and inverted three-state outputs.
// Assumes: Core clock 25 MHz; pins pass a three-stage synchroniser.
// Notes:   Each three-state output is a level and an enable signal; the wire is resolved outside.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Function
// RULE1: Four-bit select code fully decoded routes exactly one of sixteen inputs.
// RULE2: True output carries selected level, inverted output carries its complement.
// RULE3: Clocked variant registers the select code before the decoder.
// RULE4: Hold variant keeps select code in a register governed by hold enable.
// RULE5: Output drives only with master enable low and its own enable asserted.
// RULE6: Output enables never disturb select register or selection logic.
// RULE7: Cascaded parts use master enables so only one drives shared lines.
// RULE8: Code n selects input n; captured on rising edge, held until next.
// RULE9: Hold variant follows select while hold low, keeps code once high.
// RULE10: Select register content is undefined until first capture.
module rsmux_top
  import rsmux_pkg::*;
#(
  parameter rsmux_variant_t VARIANT = RSMUX_CLOCKED
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  input  wire logic [DATA_N-1:0] DATA_INPUTS,
  input  wire logic [SEL_W-1:0]  SELECT_CODE,
  input  wire logic              SELECT_HOLD_ENABLE,
  input  wire logic              MASTER_OUTPUT_ENABLE_N,
  input  wire logic              TRUE_OUTPUT_ENABLE_N,
  input  wire logic              INVERTED_OUTPUT_ENABLE,
  output logic                   TRUE_OUT,
  output logic                   TRUE_OUT_OE,
  output logic                   INV_OUT,
  output logic                   INV_OUT_OE,
  output logic                   SEL_VALID
);

  localparam int unsigned SYN_W = DATA_N + SEL_W + 4;
  localparam logic [SYN_W-1:0] SYN_IDLE = {{(SYN_W - 3){1'b0}}, CTRL_IDLE};

  ////////////////////////////////////////////////////////////////////////////
  // All pin inputs pass three flops; a change counts once stages two and three agree.

  typedef struct packed {
    logic [SYN_W-1:0] s1;
    logic [SYN_W-1:0] s2;
    logic [SYN_W-1:0] s3;
    logic [SYN_W-1:0] val;
    logic             y;
    logic             y_oe;
    logic             w;
    logic             w_oe;
  } rsmux_state_t;

  rsmux_state_t st;
  rsmux_state_t next_st;

  logic [DATA_N-1:0] data_s;
  logic [SEL_W-1:0]  sel_s;
  logic              hold_s;
  logic              g_n_s;
  logic              gy_n_s;
  logic              gw_s;
  logic              picked;

  rsmux_sel_if sel_bus ();

  assign {data_s, sel_s, hold_s, g_n_s, gy_n_s, gw_s} = st.val;

  ////////////////////////////////////////////////////////////////////////////
  // Select capture; it sees no output enable at all, so they cannot disturb it.

  rsmux_sel_reg #(
    .VARIANT (VARIANT)
  ) u_sel (
    .clk    (CORE_CLK),
    .rst    (RST),
    .sel_in (sel_s), // [RULE6]
    .hold   (hold_s),
    .sel    (sel_bus.src)
  );

  // Select code n picks input n, with the top code bit as most significant.
  assign picked = data_s[sel_bus.code]; // [RULE1] [RULE8]

  always_comb begin
    next_st    = st;
    next_st.s1 = {DATA_INPUTS, SELECT_CODE, SELECT_HOLD_ENABLE,
                  MASTER_OUTPUT_ENABLE_N, TRUE_OUTPUT_ENABLE_N, INVERTED_OUTPUT_ENABLE};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < SYN_W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.val[i] = st.s3[i];
      end
    end
    next_st.y    = picked; // [RULE2]
    next_st.w    = ~picked; // [RULE2]
    // The master enable gates both outputs at once, separating cascaded parts on shared lines.
    next_st.y_oe = !g_n_s && !gy_n_s; // [RULE5]
    next_st.w_oe = !g_n_s && gw_s; // [RULE5]
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      // Enables clear so both outputs float from reset, as on power-up.
      // Synchroniser stages start at the idle pin levels, so no enable leaks out early.
      // The inverted output starts high to stay the complement of the true one.
      st <= '{s1: SYN_IDLE, s2: SYN_IDLE, s3: SYN_IDLE, val: SYN_IDLE, y: 1'b0,
              y_oe: 1'b0, w: 1'b1, w_oe: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign TRUE_OUT    = st.y;
  assign TRUE_OUT_OE = st.y_oe;
  assign INV_OUT     = st.w;
  assign INV_OUT_OE  = st.w_oe;
  assign SEL_VALID   = sel_bus.known; // [RULE10]

  ////////////////////////////////////////////////////////////////////////////

  // Each check except a_compl sees the registered results one edge after the values that caused them.

  property p_compl;
    @(posedge CORE_CLK) disable iff (RST)
    TRUE_OUT == !INV_OUT;
  endproperty
  a_compl: assert property (p_compl) // [RULE2]
    else $error("outputs are not complementary");

  property p_inv_sel;
    @(posedge CORE_CLK) disable iff (RST)
    1'b1 |=> INV_OUT == !$past(data_s[sel_bus.code]);
  endproperty
  a_inv_sel: assert property (p_inv_sel) // [RULE2]
    else $error("inverted output is not the complement of the selected input");

  property p_sel;
    @(posedge CORE_CLK) disable iff (RST)
    1'b1 |=> TRUE_OUT == $past(data_s[sel_bus.code]);
  endproperty
  a_sel: assert property (p_sel) // [RULE1]
    else $error("wrong input routed");

  property p_y_oe;
    @(posedge CORE_CLK) disable iff (RST)
    1'b1 |=> TRUE_OUT_OE == ($past(!g_n_s) && $past(!gy_n_s));
  endproperty
  a_y_oe: assert property (p_y_oe) // [RULE5]
    else $error("true output enable wrong");

  property p_w_oe;
    @(posedge CORE_CLK) disable iff (RST)
    1'b1 |=> INV_OUT_OE == ($past(!g_n_s) && $past(gw_s));
  endproperty
  a_w_oe: assert property (p_w_oe) // [RULE5]
    else $error("inverted output enable wrong");

  property p_master;
    @(posedge CORE_CLK) disable iff (RST)
    g_n_s |=> !TRUE_OUT_OE && !INV_OUT_OE;
  endproperty
  a_master: assert property (p_master) // [RULE5]
    else $error("output drives with master enable high");

  property p_w_off;
    @(posedge CORE_CLK) disable iff (RST)
    (g_n_s || !gw_s) |=> !INV_OUT_OE;
  endproperty
  a_w_off: assert property (p_w_off) // [RULE5]
    else $error("inverted output drives while disabled");

  property p_capture;
    @(posedge CORE_CLK) disable iff (RST)
    (VARIANT == RSMUX_CLOCKED) |=> sel_bus.code == $past(sel_s);
  endproperty
  a_capture: assert property (p_capture) // [RULE8]
    else $error("select not captured on edge");

  property p_oe_free;
    @(posedge CORE_CLK) disable iff (RST)
    (VARIANT == RSMUX_CLOCKED && !TRUE_OUT_OE && !INV_OUT_OE) |=>
      sel_bus.code == $past(sel_s);
  endproperty
  a_oe_free: assert property (p_oe_free) // [RULE6]
    else $error("select blocked while outputs float");

  property p_clk_reg;
    @(posedge CORE_CLK) disable iff (RST)
    (VARIANT == RSMUX_CLOCKED && $stable(sel_s)) |=> $stable(sel_bus.code);
  endproperty
  a_clk_reg: assert property (p_clk_reg) // [RULE3]
    else $error("applied select changed without input change");

  property p_follow;
    @(posedge CORE_CLK) disable iff (RST)
    (VARIANT == RSMUX_HOLD && !hold_s) |=> sel_bus.code == $past(sel_s);
  endproperty
  a_follow: assert property (p_follow) // [RULE4]
    else $error("select not followed while hold low");

  property p_hold_cap;
    @(posedge CORE_CLK) disable iff (RST)
    (VARIANT == RSMUX_HOLD && hold_s && !$past(hold_s)) |=> sel_bus.code == $past(sel_s);
  endproperty
  a_hold_cap: assert property (p_hold_cap) // [RULE9]
    else $error("select not taken at hold rising edge");

  property p_known;
    @(posedge CORE_CLK) disable iff (RST)
    $fell(RST) |-> ##1 SEL_VALID;
  endproperty
  a_known: assert property (p_known) // [RULE10]
    else $error("select never known");

  property p_valid_stays;
    @(posedge CORE_CLK) disable iff (RST)
    SEL_VALID |=> SEL_VALID;
  endproperty
  a_valid_stays: assert property (p_valid_stays) // [RULE10]
    else $error("select validity dropped");

endmodule : rsmux_top

/* test/rsmux_bench.sv */
// Purpose: Self-checking bench for the selector, clocked and hold variants.
// Assumes: Fixed settle of eight cycles covers the synchroniser latency.
// Notes:   Both variants share every input pin.
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t output mismatch", $time); end end
module rsmux_bench;
  import rsmux_pkg::*;
  logic        clk = 0, rst = 1, h = 0, gn = 0, yn = 0, w = 1;
  logic [15:0] d = 16'h0000;
  logic [3:0]  s = 4'h0;
  wire         to, toe, io, ioe, sv, hto, yl, wl;
  int          errors = 0, check_count = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  rsmux_top #(.VARIANT(RSMUX_CLOCKED)) rsmux_top_inst (.CORE_CLK(clk), .RST(rst),
    .DATA_INPUTS(d), .SELECT_CODE(s), .SELECT_HOLD_ENABLE(h), .MASTER_OUTPUT_ENABLE_N(gn),
    .TRUE_OUTPUT_ENABLE_N(yn), .INVERTED_OUTPUT_ENABLE(w), .TRUE_OUT(to),
    .TRUE_OUT_OE(toe), .INV_OUT(io), .INV_OUT_OE(ioe), .SEL_VALID(sv));
  rsmux_top #(.VARIANT(RSMUX_HOLD)) rsmux_top_hold_inst (.CORE_CLK(clk), .RST(rst),
    .DATA_INPUTS(d), .SELECT_CODE(s), .SELECT_HOLD_ENABLE(h), .MASTER_OUTPUT_ENABLE_N(gn),
    .TRUE_OUTPUT_ENABLE_N(yn), .INVERTED_OUTPUT_ENABLE(w), .TRUE_OUT(hto),
    .TRUE_OUT_OE(), .INV_OUT(), .INV_OUT_OE(), .SEL_VALID());
  rsmux_bus_model rsmux_bus_model_inst (.clk(clk), .drv(to), .oe(toe), .line(yl));
  rsmux_bus_model rsmux_bus_model_w_inst (.clk(clk), .drv(io), .oe(ioe), .line(wl));
  //////////////////////////////////////////////////////////////////////////////
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task sweep();
    for (int n = 0; n < 16; n++) begin
      @(posedge clk);
      s <= 4'(n);
      d <= 16'h0001 << n;
      wt(8);
      `CHK(yl, 1'b1)
      `CHK(wl, 1'b0)
      @(posedge clk);
      d <= ~(16'h0001 << n);
      wt(8);
      `CHK({yl, wl}, 2'b01)
    end
  endtask : sweep
  task enables();
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      {gn, yn, w} <= 3'(k);
      wt(8);
      `CHK(toe, !k[2] && !k[1])
      `CHK(ioe, !k[2] && k[0])
    end
    @(posedge clk);
    gn <= 1'b1;
    s <= 4'h3;
    d <= 16'h0008;
    wt(8);
    `CHK({toe, ioe, to, io}, 4'b0010)
    @(posedge clk);
    {gn, yn, w} <= 3'b001;
    wt(8);
    `CHK({yl, wl}, 2'b10)
  endtask : enables
  task hold();
    @(posedge clk);
    h <= 1'b1;
    wt(8);
    @(posedge clk);
    s <= 4'h4;
    wt(8);
    `CHK(hto, 1'b1)
    `CHK(yl, 1'b0)
    @(posedge clk);
    h <= 1'b0;
    wt(8);
    `CHK(hto, 1'b0)
  endtask : hold
  task end_of_test();
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Whole run is under 1000 cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (11) @(posedge clk);
    #1;
    `CHK({toe, ioe, sv}, 3'b000)
    @(posedge clk);
    rst <= 1'b0;
    wt(6);
    `CHK(sv, 1'b1)
    sweep();
    enables();
    hold();
    end_of_test();
  end
endmodule : rsmux_bench

/* test/rsmux_bus_model.sv */
// Purpose: Shared bus line seen by the selector's three-state output.
// Assumes: One driver on the line; no pull resistor.
// Notes:   A released line shows the inverse of the last driven level.
`timescale 1ns/10ps
module rsmux_bus_model (
  input  wire logic clk,
  input  wire logic drv,
  input  wire logic oe,
  output logic      line
);
  logic last = 1'b0;
  // A stale level would hide a late output enable, so the idle line flips.
  always @(posedge clk) begin
    if (oe) begin
      last <= drv;
    end
  end
  assign line = oe ? drv : ~last;
endmodule : rsmux_bus_model
